/* File: design/mmvd_top.sv */
/*
 * Memory map and vector decoder: RAM, monitor ROM, vector table,
 * supply monitor, flash protect start, watchdog clear and stack pointer.
 * Assumes a classic 8-bit Wishbone master on CLK_SYS and a CPU core
 * that issues stack commands and interrupt requests on the same clock.
 */
// Behaviour
// - Supply monitor register: bit 7 read-only trip flag, bit 5 level select.
// - Top address reads reset vector low byte; any write clears watchdog.
// - Vectors are byte pairs at the top, high byte at even address.
// - Serial vectors: transmit, receive, error from the lowest vector up.
// - Converter then second timer overflow, channel 1, channel 0 vectors.
// - First timer: overflow, four reserved bytes, channel 1, channel 0.
// - Upper vectors: motor PWM, faults, PLL, external, software, reset.
// - Higher vector address means higher interrupt priority.
// - Monitor ROM is decoded read-only in its reserved range.
// - 256 bytes of read/write RAM over its fixed contiguous range.
// - Stack pointer is 16 bits; software keeps it inside RAM.
// - 160 RAM bytes lie in page zero.
// - Stack pointer resets to its page-zero location.
// - Interrupt entry pushes five context bytes, no index-high byte.
// - Subroutine call pushes a two-byte return address.
// - Stack pointer decrements on push and increments on pull.
// - From protect start to top of memory high voltage cannot enable.
`timescale 1ns/100ps
module mmvd_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_SEL_I,
  input  wire logic [15:0] WB_ADR_I,
  input  wire logic [7:0]  WB_DAT_I,
  output logic      [7:0]  WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SUPPLY_TRIP,
  output logic             TRIP_LEVEL_SEL,
  output logic             WDOG_CLEAR,
  output logic             HV_ENABLE,
  input  wire logic [16:0] INT_REQ,
  output logic             INT_PENDING,
  output logic      [15:0] INT_VECTOR,
  input  wire logic [2:0]  STACK_OP,
  input  wire logic [15:0] STACK_LOAD,
  output logic      [15:0] STACK_PTR,
  output logic             STACK_IN_PAGE0
);
  mmvd_pkg::mmvd_req_type  req;
  mmvd_pkg::mmvd_spop_type sp_op;
  logic [7:0]  ram_mem [0:255];
  logic [7:0]  vec_mem [0:mmvd_pkg::VEC_BYTES-1];
  logic        ack_q, trip_s1_q, trip_s2_q, tsel_q;
  logic        wren_q, hven_q, wdog_q, pend_q;
  logic [7:0]  dat_q, prot_q;
  logic [15:0] sp_q, sp_d, lat_q, ivec_q;
  logic        take, wr, in_ram, in_rom, in_vec, in_flash;
  logic        is_sup, is_prot, is_wdog, is_vctl, prot_hit, lat_hit;
  logic        prot_none, vec_wr, pg0_q;
  logic [15:0] ram_off, vec_off, prot_start;
  logic [7:0]  rd_data, sup_rd, vctl_rd;
  logic        win_any;
  logic [4:0]  win_idx;

  // Request carrier and handshake; one wait state, ack drops after one.
  assign req     = '{adr: WB_ADR_I, we: WB_WE_I, sel: WB_SEL_I,
                     dat: WB_DAT_I};
  assign take    = CLK_EN & WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr      = take & req.we & req.sel;
  assign sp_op   = mmvd_pkg::mmvd_spop_type'(STACK_OP);

  // Address decode of every region and register.
  assign in_ram  = req.adr >= mmvd_pkg::RAM_LO &&
                   req.adr <= mmvd_pkg::RAM_HI;
  assign in_rom  = req.adr >= mmvd_pkg::ROM_LO &&
                   req.adr <= mmvd_pkg::ROM_HI;
  assign in_vec  = req.adr >= mmvd_pkg::VEC_LO;
  assign in_flash = req.adr >= mmvd_pkg::FLASH_LO && !in_rom &&
                    !is_sup && !is_prot && !is_vctl && !is_wdog;
  assign is_sup  = req.adr == mmvd_pkg::ADDR_SUPPLY;
  assign is_prot = req.adr == mmvd_pkg::ADDR_PROTECT;
  assign is_wdog = req.adr == mmvd_pkg::ADDR_WDOG;
  assign is_vctl = req.adr == mmvd_pkg::ADDR_VEC_CTRL;
  assign ram_off = req.adr - mmvd_pkg::RAM_LO;
  assign vec_off = req.adr - mmvd_pkg::VEC_LO;

  // Protected range runs from the protect start up to the top of memory.
  // The reset value protects nothing, so vectors stay writable until
  // software narrows the range on purpose.
  assign prot_start = {2'b11, prot_q, 6'h00};
  assign prot_none  = prot_q == mmvd_pkg::PROTECT_RST;
  assign prot_hit   = !prot_none && req.adr >= prot_start;
  assign lat_hit    = !prot_none && lat_q >= prot_start;
  // Vector bytes store only when enabled and unprotected; the top byte
  // is the watchdog clear and is never stored.
  assign vec_wr     = wr && in_vec && !is_wdog && wren_q && !prot_hit;

  // Read data selection; unmapped addresses read zero.
  assign sup_rd  = {trip_s2_q, 1'b0, tsel_q, 5'h00};
  assign vctl_rd = {6'h00, hven_q, wren_q};
  assign rd_data = is_sup  ? sup_rd :
                   is_prot ? prot_q :
                   is_vctl ? vctl_rd :
                   in_vec  ? vec_mem[vec_off[5:0]] :
                   in_rom  ? mmvd_pkg::ROM_FILL :
                   in_ram  ? ram_mem[ram_off[7:0]] : 8'h00;

  // Bus answer register; reads never disturb any other state.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else if (CLK_EN) begin
      ack_q <= take;
      if (take) begin
        dat_q <= rd_data;
      end
    end
  end

  // Trip flag comes from the analogue comparator, so it is synchronised.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      trip_s1_q <= 1'b0;
      trip_s2_q <= 1'b0;
    end else if (CLK_EN) begin
      trip_s1_q <= SUPPLY_TRIP;
      trip_s2_q <= trip_s1_q;
    end
  end

  // Control registers; the protect start resets to protect nothing.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      tsel_q <= mmvd_pkg::SUPPLY_RST[mmvd_pkg::TSEL_BIT];
      prot_q <= mmvd_pkg::PROTECT_RST;
      wren_q <= 1'b0;
      wdog_q <= 1'b0;
    end else if (CLK_EN) begin
      wdog_q <= wr & is_wdog;
      if (wr && is_sup) begin
        tsel_q <= req.dat[mmvd_pkg::TSEL_BIT];
      end
      if (wr && is_prot) begin
        prot_q <= req.dat;
      end
      if (wr && is_vctl) begin
        wren_q <= req.dat[mmvd_pkg::WREN_BIT];
      end
    end
  end

  // High voltage is refused while the last flash target is protected.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      hven_q <= 1'b0;
      lat_q  <= 16'h0000;
    end else if (CLK_EN) begin
      if (wr && in_flash) begin
        lat_q <= req.adr;
      end
      if (wr && is_vctl) begin
        hven_q <= req.dat[mmvd_pkg::HVEN_BIT] & ~lat_hit;
      end
    end
  end

  // Memories carry no reset, so they read unknown until written.
  always_ff @(posedge CLK_SYS) begin
    if (CLK_EN && wr && in_ram) begin
      ram_mem[ram_off[7:0]] <= req.dat;
    end
    if (vec_wr) begin
      vec_mem[vec_off[5:0]] <= req.dat;
    end
  end

  // Highest pending source wins: later index means higher address.
  always_comb begin
    win_any = 1'b0;
    win_idx = 5'h00;
    for (int i = 0; i < mmvd_pkg::VEC_SRCS; i++) begin
      if (INT_REQ[i]) begin
        win_any = 1'b1;
        win_idx = 5'(i);
      end
    end
  end

  // Vector address for the winner, from the fixed table.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pend_q <= 1'b0;
      ivec_q <= 16'hFFFE;
    end else if (CLK_EN) begin
      pend_q <= win_any;
      ivec_q <= mmvd_pkg::mmvd_vec_addr(win_idx);
    end
  end

  // Stack pointer update; the index-high byte is not part of the frame.
  always_comb begin
    sp_d = sp_q;
    unique case (sp_op)
      mmvd_pkg::SP_PUSH: sp_d = sp_q - 16'h0001;
      mmvd_pkg::SP_PULL: sp_d = sp_q + 16'h0001;
      mmvd_pkg::SP_INT:  sp_d = sp_q - mmvd_pkg::INT_FRAME;
      mmvd_pkg::SP_RTI:  sp_d = sp_q + mmvd_pkg::INT_FRAME;
      mmvd_pkg::SP_CALL: sp_d = sp_q - mmvd_pkg::CALL_FRAME;
      mmvd_pkg::SP_RTS:  sp_d = sp_q + mmvd_pkg::CALL_FRAME;
      mmvd_pkg::SP_LOAD: sp_d = STACK_LOAD;
      mmvd_pkg::SP_NONE: sp_d = sp_q;
    endcase
  end

  // Page-zero RAM starts with RAM and ends at the page boundary.
  function automatic logic in_page0(input logic [15:0] a);
    return (a >= mmvd_pkg::RAM_LO) && (a <= mmvd_pkg::PAGE0_HI);
  endfunction : in_page0

  // Full 16-bit pointer; keeping it in RAM is the software's duty.
  // The page-zero flag is taken from the next value so that it stays
  // aligned with the pointer and still leaves from a flip-flop.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      sp_q  <= mmvd_pkg::SP_RST;
      pg0_q <= in_page0(mmvd_pkg::SP_RST);
    end else if (CLK_EN) begin
      sp_q  <= sp_d;
      pg0_q <= in_page0(sp_d);
    end
  end

  // Outputs straight from flip-flops.
  assign WB_ACK_O       = ack_q;
  assign WB_DAT_O       = dat_q;
  assign TRIP_LEVEL_SEL = tsel_q;
  assign WDOG_CLEAR     = wdog_q;
  assign HV_ENABLE      = hven_q;
  assign INT_PENDING    = pend_q;
  assign INT_VECTOR     = ivec_q;
  assign STACK_PTR      = sp_q;
  assign STACK_IN_PAGE0 = pg0_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  sup_read_a: assert property (CLK_EN && take && !req.we && is_sup |=>
    WB_DAT_O == {$past(trip_s2_q), 1'b0, $past(tsel_q), 5'h00})
    else $error("supply register read wrong");
  wdog_clr_a: assert property (CLK_EN && wr && is_wdog |->
    !vec_wr ##1 WDOG_CLEAR)
    else $error("watchdog clear missing");
  ack_pulse_a: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
    else $error("ack held too long");
  prio_a: assert property (CLK_EN && INT_REQ[16] |=>
    INT_VECTOR == 16'hFFFE && INT_PENDING)
    else $error("reset vector not highest");
  tx_vec_a: assert property (CLK_EN && INT_REQ == 17'h00001 |=>
    INT_VECTOR == 16'hFFD2)
    else $error("serial transmit vector wrong");
  sp_int_a: assert property (CLK_EN && sp_op == mmvd_pkg::SP_INT |=>
    STACK_PTR == $past(STACK_PTR) - 16'h0005)
    else $error("interrupt frame not five bytes");
  sp_call_a: assert property (CLK_EN && sp_op == mmvd_pkg::SP_CALL |=>
    STACK_PTR == $past(STACK_PTR) - 16'h0002)
    else $error("call frame not two bytes");
  sp_push_a: assert property (CLK_EN && sp_op == mmvd_pkg::SP_PUSH ##1
    CLK_EN && sp_op == mmvd_pkg::SP_PULL |=> STACK_PTR == $past(sp_q, 2))
    else $error("push and pull not balanced");
  hv_guard_a: assert property ($rose(hven_q) |->
    $past(prot_q) == 8'hFF ||
    $past(lat_q) < {2'b11, $past(prot_q), 6'h00})
    else $error("high voltage in protected range");
  ram_rw_a: assert property (CLK_EN && wr && in_ram ##2 !take ##1
    take && !req.we && req.adr == $past(req.adr, 3) |=>
    WB_DAT_O == $past(req.dat, 4))
    else $error("RAM read back wrong");
  // Enable low freezes the pointer and the bus answer alike.
  en_freeze_a: assert property (!CLK_EN |=>
    STACK_PTR == $past(STACK_PTR) && WB_ACK_O == $past(WB_ACK_O))
    else $error("state moved while enable low");
  rom_read_a: assert property (take && !req.we && in_rom |=>
    WB_DAT_O == mmvd_pkg::ROM_FILL)
    else $error("monitor ROM read wrong");
  page0_flag_a: assert property (STACK_IN_PAGE0 ==
    (STACK_PTR - 16'h0060 < 16'h00A0))
    else $error("page-zero flag wrong");
endmodule : mmvd_top

/* File: include/mmvd_pkg.sv */
/*
 * Shared constants and types of the memory map and vector decoder.
 * Assumes an 8-bit classic Wishbone master with a 16-bit byte address.
 */
package mmvd_pkg;
  // Fixed register addresses; the vector control word sits in a free slot.
  localparam logic [15:0] ADDR_SUPPLY   = 16'hFE0F;
  localparam logic [15:0] ADDR_PROTECT  = 16'hFF7E;
  localparam logic [15:0] ADDR_WDOG     = 16'hFFFF;
  localparam logic [15:0] ADDR_VEC_CTRL = 16'hFE0B;
  // Memory regions.
  localparam logic [15:0] RAM_LO   = 16'h0060;
  localparam logic [15:0] RAM_HI   = 16'h015F;
  localparam logic [15:0] PAGE0_HI = 16'h00FF;
  localparam logic [15:0] ROM_LO   = 16'hFE10;
  localparam logic [15:0] ROM_HI   = 16'hFF48;
  localparam logic [15:0] FLASH_LO = 16'hE000;
  localparam logic [15:0] VEC_LO   = 16'hFFD2;
  localparam int          VEC_BYTES = 46;
  localparam int          VEC_SRCS  = 17;
  // Field positions and reset values.
  localparam int          TRIP_BIT    = 7;
  localparam int          TSEL_BIT    = 5;
  localparam int          WREN_BIT    = 0;
  localparam int          HVEN_BIT    = 1;
  localparam logic [7:0]  SUPPLY_RST  = 8'h00;
  localparam logic [7:0]  PROTECT_RST = 8'hFF;
  localparam logic [7:0]  ROM_FILL    = 8'h9D;
  localparam logic [15:0] SP_RST      = 16'h00FF;
  localparam logic [15:0] INT_FRAME   = 16'h0005;
  localparam logic [15:0] CALL_FRAME  = 16'h0002;

  // Stack pointer commands from the core.
  typedef enum logic [2:0] {
    SP_NONE = 3'h0, SP_PUSH = 3'h1, SP_PULL = 3'h2, SP_INT = 3'h3,
    SP_RTI  = 3'h4, SP_CALL = 3'h5, SP_RTS  = 3'h6, SP_LOAD = 3'h7
  } mmvd_spop_type;

  // One bus request as it is taken.
  typedef struct packed {
    logic [15:0] adr;
    logic        we;
    logic        sel;
    logic [7:0]  dat;
  } mmvd_req_type;

  // Vector address of source n, lowest priority first; n = 16 is reset.
  function automatic logic [15:0] mmvd_vec_addr(input logic [4:0] n);
    logic [15:0] a;
    a = 16'hFFFE;
    unique case (n)
      5'h00: a = 16'hFFD2;
      5'h01: a = 16'hFFD4;
      5'h02: a = 16'hFFD6;
      5'h03: a = 16'hFFDC;
      5'h04: a = 16'hFFDE;
      5'h05: a = 16'hFFE0;
      5'h06: a = 16'hFFE2;
      5'h07: a = 16'hFFE4;
      5'h08: a = 16'hFFEA;
      5'h09: a = 16'hFFEC;
      5'h0A: a = 16'hFFEE;
      5'h0B: a = 16'hFFF0;
      5'h0C: a = 16'hFFF6;
      5'h0D: a = 16'hFFF8;
      5'h0E: a = 16'hFFFA;
      5'h0F: a = 16'hFFFC;
      default: a = 16'hFFFE;
    endcase
    return a;
  endfunction : mmvd_vec_addr
endpackage : mmvd_pkg

/* File: test/mmvd_core_model.sv */
/*
 * Core-side model: issues one stack command per go strobe and holds
 * interrupt request levels, both launched on the system clock edge.
 * Assumes the bench owns go, cmd and irq and changes them after an edge.
 */
`timescale 1ns/100ps
module mmvd_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [2:0]  cmd,
  input  wire logic [16:0] irq,
  output logic      [2:0]  stack_op = 3'h0,
  output logic      [16:0] int_req  = 17'h00000
);
  // Each edge passes the command while go is high, so a held go repeats it.
  always @(posedge clk) begin
    stack_op <= (go && rst_n) ? cmd : 3'h0;
    int_req  <= rst_n ? irq : 17'h00000;
  end
endmodule : mmvd_core_model

/* File: test/test_mmvd_top.sv */
/*
 * Self-checking bench of the memory map and vector decoder.
 * Assumes the core model beside it and a 10 MHz system clock.
 */
`timescale 1ns/100ps
module test_mmvd_top;
  typedef struct packed {
    mmvd_pkg::mmvd_req_type req;
    logic [7:0]             exp;
  } mmvd_row_type;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   stb = 1'b0;
  mmvd_pkg::mmvd_req_type req = '0;
  logic [7:0]             rd;
  logic                   wd;
  logic                   trip = 1'b0;
  logic                   go = 1'b0;
  logic                   en = 1'b1;
  logic [2:0]             cmd = 3'h0;
  logic [16:0]            irq = 17'h00000;
  logic [15:0]            load = 16'h0000;
  logic [7:0]             dat_o;
  logic                   ack, tsel, wdog, hv, pend, pg0;
  logic [15:0]            vec, sp;
  logic [2:0]             op;
  logic [16:0]            ireq;
  int                     fail_count = 0;
  int                     checks = 0;
  // Vector of each source, lowest priority first.
  logic [15:0] vtab [17] = '{16'hFFD2, 16'hFFD4, 16'hFFD6, 16'hFFDC,
    16'hFFDE, 16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFEA, 16'hFFEC, 16'hFFEE,
    16'hFFF0, 16'hFFF6, 16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE};
  // Bus rows: request, then the data a read should return.
  mmvd_row_type rows [18] = '{
    '{'{16'h0060, 1'b1, 1'b1, 8'hA5}, 8'h00},
    '{'{16'h0060, 1'b0, 1'b1, 8'h00}, 8'hA5},
    '{'{16'h015F, 1'b1, 1'b1, 8'h5A}, 8'h00},
    '{'{16'h015F, 1'b0, 1'b1, 8'h00}, 8'h5A},
    '{'{16'h00FF, 1'b1, 1'b1, 8'h3C}, 8'h00},
    '{'{16'h00FF, 1'b1, 1'b0, 8'h00}, 8'h00},
    '{'{16'h00FF, 1'b0, 1'b1, 8'h00}, 8'h3C},
    '{'{16'h0160, 1'b1, 1'b1, 8'h11}, 8'h00},
    '{'{16'h0160, 1'b0, 1'b1, 8'h00}, 8'h00},
    '{'{16'h005F, 1'b0, 1'b1, 8'h00}, 8'h00},
    '{'{16'hFE10, 1'b1, 1'b1, 8'h00}, 8'h00},
    '{'{16'hFE10, 1'b0, 1'b1, 8'h00}, 8'h9D},
    '{'{16'hFF48, 1'b0, 1'b1, 8'h00}, 8'h9D},
    '{'{16'hFE0F, 1'b0, 1'b1, 8'h00}, 8'h00},
    '{'{16'hFE0F, 1'b1, 1'b1, 8'hFF}, 8'h00},
    '{'{16'hFE0F, 1'b0, 1'b1, 8'h00}, 8'h20},
    '{'{16'hFE0F, 1'b1, 1'b1, 8'h00}, 8'h00},
    '{'{16'hFF7E, 1'b0, 1'b1, 8'h00}, 8'hFF}};
  // Stack rows: command, load value, pointer and page-zero flag after.
  logic [2:0]  sop [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7,
    3'h7};
  logic [15:0] sld [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0060, 16'h015F, 16'h005F};
  logic [15:0] ssp [9] = '{16'h00FE, 16'h00FF, 16'h00FA, 16'h00FF,
    16'h00FD, 16'h00FF, 16'h0060, 16'h015F, 16'h005F};
  logic [8:0]  spg = 9'b001111111;

  always #50 clk_sys = ~clk_sys;

  mmvd_core_model core_u (.clk(clk_sys), .rst_n(reset_n), .go(go),
    .cmd(cmd), .irq(irq), .stack_op(op), .int_req(ireq));

  mmvd_top dut_u (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(en),
    .WB_CYC_I(stb), .WB_STB_I(stb), .WB_WE_I(req.we), .WB_SEL_I(req.sel),
    .WB_ADR_I(req.adr), .WB_DAT_I(req.dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SUPPLY_TRIP(trip), .TRIP_LEVEL_SEL(tsel),
    .WDOG_CLEAR(wdog), .HV_ENABLE(hv), .INT_REQ(ireq), .INT_PENDING(pend),
    .INT_VECTOR(vec), .STACK_OP(op), .STACK_LOAD(load), .STACK_PTR(sp),
    .STACK_IN_PAGE0(pg0));

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One classic cycle; data and watchdog pulse are taken at the ack edge.
  task automatic wb(input mmvd_pkg::mmvd_req_type r);
    int n;
    n = 0;
    req <= r;
    stb <= 1'b1;
    @(posedge clk_sys);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
    end
    rd = dat_o;
    wd = wdog;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short well past the expected few hundred cycles.
  initial begin
    #(3000 * 100);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk("sp", sp, mmvd_pkg::SP_RST);
    chk("vec", vec, 16'hFFFE);
    chk("outs", {pend, tsel, wdog, hv}, 16'h0);
    @(posedge clk_sys);
    foreach (rows[i]) begin
      wb(rows[i].req);
      if (!rows[i].req.we) chk("rdata", rd, rows[i].exp);
    end
    chk("tsel", tsel, 16'h0);
    wb('{16'hFFFF, 1'b1, 1'b1, 8'h00});
    chk("wdog", wd, 16'h1);
    wb('{16'hFFFF, 1'b0, 1'b1, 8'h00});
    chk("wdog", {wd, wdog}, 16'h0);
    // Protection follows the last flash write against the start value.
    wb('{16'hE000, 1'b1, 1'b1, 8'h00});
    wb('{16'hFE0B, 1'b1, 1'b1, 8'h02});
    chk("hv", hv, 16'h1);
    // Vector bytes store once enabled while the reset value protects none.
    wb('{16'hFE0B, 1'b1, 1'b1, 8'h01});
    wb('{16'hFFD8, 1'b1, 1'b1, 8'h5A});
    wb('{16'hFFFE, 1'b1, 1'b1, 8'hC3});
    wb('{16'hFFD8, 1'b0, 1'b1, 8'h00});
    chk("reserved", {wd, rd}, 16'h5A);
    wb('{16'hFFFE, 1'b0, 1'b1, 8'h00});
    chk("vector", rd, 16'hC3);
    // A start of FF80 protects the vectors: no store, no high voltage.
    wb('{16'hFF7E, 1'b1, 1'b1, 8'hFE});
    wb('{16'hFFD8, 1'b1, 1'b1, 8'h00});
    wb('{16'hFE0B, 1'b1, 1'b1, 8'h02});
    chk("hv", hv, 16'h0);
    wb('{16'hFFD8, 1'b0, 1'b1, 8'h00});
    chk("reserved", rd, 16'h5A);
    wb('{16'hFF7E, 1'b1, 1'b1, 8'h00});
    wb('{16'hFF7E, 1'b0, 1'b1, 8'h00});
    chk("protect", rd, 16'h0);
    wb('{16'hE000, 1'b1, 1'b1, 8'h00});
    wb('{16'hFE0B, 1'b1, 1'b1, 8'h02});
    chk("hv", hv, 16'h0);
    // Trip flag passes two synchroniser stages and ignores writes.
    trip <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wb('{16'hFE0F, 1'b1, 1'b1, 8'h00});
    wb('{16'hFE0F, 1'b0, 1'b1, 8'h00});
    chk("trip", rd, 16'h80);
    foreach (sop[i]) begin
      go <= 1'b1;
      cmd <= sop[i];
      load <= sld[i];
      @(posedge clk_sys);
      go <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("sp", sp, ssp[i]);
      chk("page0", pg0, spg[i]);
      @(posedge clk_sys);
    end
    // Enable low freezes a held push; then a push and a pull back to back.
    en  <= 1'b0;
    go  <= 1'b1;
    cmd <= 3'h1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("frozen", sp, 16'h005F);
    @(posedge clk_sys);
    en  <= 1'b1;
    cmd <= 3'h2;
    @(posedge clk_sys);
    go  <= 1'b0;
    #1;
    chk("push", sp, 16'h005E);
    @(posedge clk_sys);
    #1;
    chk("pull", sp, 16'h005F);
    @(posedge clk_sys);
    // All sources up to i request; the highest address must win.
    for (int i = 0; i < 17; i++) begin
      irq <= (17'h00001 << (i + 1)) - 17'h00001;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("vector", vec, vtab[i]);
      chk("pending", pend, 16'h1);
      @(posedge clk_sys);
    end
    irq <= 17'h00000;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("pending", pend, 16'h0);
    // A second reset in mid-run restores the registers it owns.
    @(posedge clk_sys);
    wb('{16'hFE0F, 1'b1, 1'b1, 8'h20});
    chk("tsel", tsel, 16'h1);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk("sp", sp, mmvd_pkg::SP_RST);
    chk("page0", pg0, 16'h1);
    chk("vec", vec, 16'hFFFE);
    chk("outs", {pend, tsel, wdog, hv}, 16'h0);
    @(posedge clk_sys);
    wb('{16'hFF7E, 1'b0, 1'b1, 8'h00});
    chk("protect", rd, 16'hFF);
    end_sim();
  end
endmodule : test_mmvd_top
